// [inc/reed_mux_pkg.sv]
package reed_mux_pkg;

    // Bank geometry
    localparam int          BANK_REEDS = 40;
    localparam int          BANK_BUS   = 4;
    localparam int          TWO_HI     = 20;
    localparam logic [5:0]  LO_OFS     = 6'h14;

    // Request channel space: channels first, bus relays from BUS_BASE
    localparam logic [6:0]  SPAN_TWO   = 7'h28;
    localparam logic [6:0]  SPAN_ONE   = 7'h50;
    localparam logic [6:0]  BANK_TWO   = 7'h14;
    localparam logic [6:0]  BANK_ONE   = 7'h28;
    localparam logic [6:0]  BUS_BASE   = 7'h50;
    localparam logic [6:0]  BUS_COUNT  = 7'h08;

    // Load limits in half-channel units
    localparam logic [7:0]  LIM_TWO_TOTAL = 8'h28;
    localparam logic [7:0]  LIM_TWO_BANK  = 8'h14;
    localparam logic [7:0]  LIM_ONE_TOTAL = 8'h50;
    localparam logic [7:0]  LIM_ONE_BANK  = 8'h28;
    localparam logic [7:0]  W_CHAN        = 8'h02;
    localparam logic [7:0]  W_BUS         = 8'h01;

    // Break-before-make gap
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          BREAK_TIME_NS = 1000;
    localparam logic [8:0]  BREAK_CYC     =
        9'((BREAK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Identity codes, values arbitrary
    localparam logic [15:0] ID_TWO_WIRE = 16'hA5C2;
    localparam logic [15:0] ID_ONE_WIRE = 16'hA5C1;

    typedef enum logic [1:0] {
        OP_OPEN     = 2'b00,
        OP_CLOSE    = 2'b01,
        OP_SCAN     = 2'b10,
        OP_OPEN_ALL = 2'b11
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BREAK = 2'b01,
        ST_EXEC  = 2'b10
    } state_e;

endpackage

// [design/intlk_sync.sv]
`timescale 1ns/1ns
module intlk_sync
    import reed_mux_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Pin and clean level
    input  wire logic pin_in,
    output logic      level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Reset low: a lost interlock is the safe assumption
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

endmodule

// [design/relay_bank.sv]
`timescale 1ns/1ns
module relay_bank
    import reed_mux_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Mode and interlock
    input  wire logic        one_wire,
    input  wire logic        intlk_ok,
    // Write port
    input  wire logic        open_all,
    input  wire logic        ch_we,
    input  wire logic [5:0]  ch_idx,
    input  wire logic        ch_val,
    input  wire logic        bus_we,
    input  wire logic [1:0]  bus_idx,
    input  wire logic        bus_val,
    // Relay drive and load
    output logic [39:0]      reed_q,
    output logic [3:0]       bus_q,
    output logic [7:0]       ch_load,
    output logic [7:0]       bus_load
);

    logic [3:0] bus_d;

    // Reeds open at reset, the power-off state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reed_q <= '0;
        end else if (open_all) begin
            reed_q <= '0;
        end else if (ch_we) begin
            reed_q[ch_idx] <= ch_val;
            // Two-wire drives HI and LO reeds; one-wire only HI
            if (!one_wire) begin
                reed_q[6'(ch_idx + LO_OFS)] <= ch_val;
            end
        end
    end

    // Bus relays open on interlock loss with no request needed; closing needs a write
    for (genvar g = 0; g < BANK_BUS; g++) begin : g_bus
        always_comb begin
            if (!intlk_ok) begin
                bus_d[g] = 1'b0;
            end else if (bus_we && bus_idx == 2'(g)) begin
                bus_d[g] = bus_val;
            end else begin
                bus_d[g] = bus_q[g];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_q <= '0;
        end else begin
            bus_q <= bus_d;
        end
    end

    // Load: channel weighs two halves, bus relay one
    always_comb begin
        logic [6:0] n;
        n = '0;
        for (int i = 0; i < BANK_REEDS; i++) begin
            if (one_wire || i < TWO_HI) begin
                n = n + 7'(reed_q[i]);
            end
        end
        ch_load  = {n, 1'b0};
        bus_load = 8'(bus_q[0]) + 8'(bus_q[1])
                 + 8'(bus_q[2]) + 8'(bus_q[3]);
    end

    // Interlock loss empties this bank's bus relays on the next edge
    intlk_open_a: assert property (@(posedge clk_sys) disable iff (reset)
        !intlk_ok |=> bus_q == 4'h0)
        else $error("bank bus relay held without interlock");

endmodule

// [design/reed_mux_relay_controller.sv]
`timescale 1ns/1ns
module reed_mux_relay_controller
    import reed_mux_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Mode strap and interlock pins
    input  wire logic        one_wire_sel,
    input  wire logic [1:0]  intlk_pin,
    // Request from the mainframe controller
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_op,
    input  wire logic [6:0]  req_chan,
    input  wire logic        req_four_wire,
    output logic             req_ready_q,
    // Answer
    output logic             resp_valid_q,
    output logic             resp_err_q,
    output logic             scan_busy_q,
    // Module type query
    input  wire logic        module_type_query,
    output logic             ident_valid_q,
    output logic [15:0]      ident_code_q,
    output logic             one_wire_q,
    // Relay drive
    output logic [79:0]      chan_relay,
    output logic [7:0]       bus_relay
);

    state_e      state_q;
    state_e      state_d;
    logic        armed_q;
    logic [8:0]  break_cnt_q;
    logic [1:0]  intlk_ok;

    // Latched target of an accepted request
    op_e         tgt_op_q;
    logic [5:0]  tgt_local_q;
    logic        tgt_bank_q;
    logic        tgt_pair_q;
    logic        tgt_bus_q;
    logic        tgt_bus_bank_q;
    logic [1:0]  tgt_bus_idx_q;

    // Per-bank views
    logic [39:0] reed [2];
    logic [3:0]  bus  [2];
    logic [7:0]  ch_load [2];
    logic [7:0]  bus_load [2];
    logic [1:0]  open_all_b;
    logic [1:0]  ch_we_b;
    logic [1:0]  bus_we_b;

    // Request decode
    op_e         op;
    logic        take;
    logic        is_bus;
    logic        is_ch;
    logic        hi_bank;
    logic        pair;
    logic        bus_bank;
    logic [1:0]  bus_idx;
    logic [6:0]  bus_off;
    logic [6:0]  span;
    logic [6:0]  bank_size;
    logic [5:0]  local_idx;
    logic [7:0]  proj [2];
    logic [7:0]  total;
    logic [7:0]  lim_bank;
    logic [7:0]  lim_total;
    logic        fits;
    logic        legal;
    logic        ok;

    // Interlock pins pass the pin synchroniser
    for (genvar b = 0; b < 2; b++) begin : g_bank
        intlk_sync u_sync (
            .clk_sys (clk_sys),
            .reset   (reset),
            .pin_in  (intlk_pin[b]),
            .level_q (intlk_ok[b])
        );

        relay_bank u_bank (
            .clk_sys  (clk_sys),
            .reset    (reset),
            .one_wire (one_wire_q),
            .intlk_ok (intlk_ok[b]),
            .open_all (open_all_b[b]),
            .ch_we    (ch_we_b[b]),
            .ch_idx   (tgt_local_q),
            .ch_val   (tgt_op_q != OP_OPEN),
            .bus_we   (bus_we_b[b]),
            .bus_idx  (tgt_bus_idx_q),
            .bus_val  (tgt_op_q != OP_OPEN),
            .reed_q   (reed[b]),
            .bus_q    (bus[b]),
            .ch_load  (ch_load[b]),
            .bus_load (bus_load[b])
        );
    end

    assign chan_relay = {reed[1], reed[0]};
    assign bus_relay  = {bus[1], bus[0]};

    // Mode strap caught once after reset; later changes wait for reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            armed_q    <= 1'b0;
            one_wire_q <= 1'b0;
        end else if (!armed_q) begin
            armed_q    <= 1'b1;
            one_wire_q <= one_wire_sel;
        end
    end

    // Address decode of the requested channel
    always_comb begin
        op        = op_e'(req_op);
        take      = req_valid && req_ready_q;
        span      = one_wire_q ? SPAN_ONE : SPAN_TWO;
        bank_size = one_wire_q ? BANK_ONE : BANK_TWO;
        lim_bank  = one_wire_q ? LIM_ONE_BANK : LIM_TWO_BANK;
        lim_total = one_wire_q ? LIM_ONE_TOTAL : LIM_TWO_TOTAL;
        bus_off   = req_chan - BUS_BASE;
        is_bus    = (req_chan >= BUS_BASE) && (bus_off < BUS_COUNT);
        is_ch     = req_chan < span;
        hi_bank   = req_chan >= bank_size;
        if (hi_bank) begin
            local_idx = 6'(req_chan - bank_size);
        end else begin
            local_idx = 6'(req_chan);
        end
        pair      = req_four_wire && !one_wire_q;
        bus_bank  = bus_off[2];
        bus_idx   = bus_off[1:0];
    end

    // Projected load of each bank if the request were carried out
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            proj[b] = bus_load[b];
            if (op != OP_SCAN) begin
                proj[b] = proj[b] + ch_load[b];
            end
            // Scan first opens every channel, so only its target counts
            if (is_ch && (pair || hi_bank == 1'(b))
                && (op == OP_SCAN || !reed[b][local_idx])) begin
                proj[b] = proj[b] + W_CHAN;
            end
            if (is_bus && bus_bank == 1'(b) && !bus[b][bus_idx]) begin
                proj[b] = proj[b] + W_BUS;
            end
        end
        total = proj[0] + proj[1];
        fits  = (proj[0] <= lim_bank) && (proj[1] <= lim_bank)
             && (total <= lim_total);
        // Four-wire pairs exist only for bank one channels in two-wire
        legal = (op == OP_OPEN_ALL)
             || (is_ch && !(req_four_wire && (one_wire_q || hi_bank)))
             || (is_bus && op != OP_SCAN);
        if (!legal) begin
            ok = 1'b0;
        end else if (op == OP_OPEN || op == OP_OPEN_ALL) begin
            ok = 1'b1;
        end else if (is_bus) begin
            ok = fits && intlk_ok[bus_bank];
        end else begin
            ok = fits;
        end
    end

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take && ok) begin
                    state_d = (op == OP_SCAN) ? ST_BREAK : ST_EXEC;
                end
            end
            ST_BREAK: begin
                if (break_cnt_q == BREAK_CYC - 9'h001) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Break gap counter, kept short so a step fits a 2 ms scan slot
    always_ff @(posedge clk_sys) begin
        if (reset || state_q != ST_BREAK) begin
            break_cnt_q <= 9'h000;
        end else begin
            break_cnt_q <= break_cnt_q + 9'h001;
        end
    end

    // Target latch; a refused request leaves it and the relays alone
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tgt_op_q       <= OP_OPEN;
            tgt_local_q    <= 6'h00;
            tgt_bank_q     <= 1'b0;
            tgt_pair_q     <= 1'b0;
            tgt_bus_q      <= 1'b0;
            tgt_bus_bank_q <= 1'b0;
            tgt_bus_idx_q  <= 2'h0;
        end else if (take && ok) begin
            tgt_op_q       <= op;
            tgt_local_q    <= local_idx;
            tgt_bank_q     <= hi_bank;
            tgt_pair_q     <= pair;
            tgt_bus_q      <= is_bus;
            tgt_bus_bank_q <= bus_bank;
            tgt_bus_idx_q  <= bus_idx;
        end
    end

    // Bank write strobes
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            open_all_b[b] = (take && ok && op == OP_SCAN)
                || (state_q == ST_EXEC && tgt_op_q == OP_OPEN_ALL);
            ch_we_b[b] = state_q == ST_EXEC && !tgt_bus_q
                && tgt_op_q != OP_OPEN_ALL
                && (tgt_pair_q || tgt_bank_q == 1'(b));
            bus_we_b[b] = state_q == ST_EXEC && tgt_bus_q
                && tgt_op_q != OP_OPEN_ALL && tgt_bus_bank_q == 1'(b);
        end
    end

    // Answer and handshake flags
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resp_valid_q <= 1'b0;
            resp_err_q   <= 1'b0;
            req_ready_q  <= 1'b0;
            scan_busy_q  <= 1'b0;
        end else begin
            resp_valid_q <= (take && !ok) || state_q == ST_EXEC;
            resp_err_q   <= take && !ok;
            req_ready_q  <= armed_q && state_d == ST_IDLE;
            scan_busy_q  <= state_d == ST_BREAK;
        end
    end

    // Identity answer follows the mode caught after reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ident_valid_q <= 1'b0;
            ident_code_q  <= 16'h0000;
        end else begin
            ident_valid_q <= module_type_query;
            if (module_type_query) begin
                ident_code_q <= one_wire_q ? ID_ONE_WIRE
                                           : ID_TWO_WIRE;
            end
        end
    end

    // Checks
    sequence scan_start_s;
        take && ok && op == OP_SCAN;
    endsequence
    sequence scan_break_s;
        (chan_relay == 80'h0) [*8];
    endsequence
    bus_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(bus_relay[0]) |-> $past(intlk_ok[0]))
        else $error("bus relay closed without interlock");
    intlk_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
        !intlk_ok[1] |=> bus_relay[7:4] == 4'h0)
        else $error("bus relays held after interlock loss");
    bank_limit_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ch_load[0] + bus_load[0]) <= lim_bank
        && (ch_load[1] + bus_load[1]) <= lim_bank)
        else $error("bank load over limit");
    total_limit_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ch_load[0] + bus_load[0] + ch_load[1] + bus_load[1]) <= lim_total)
        else $error("module load over limit");
    refuse_err_a: assert property (@(posedge clk_sys) disable iff (reset)
        (take && !ok) |=> resp_valid_q && resp_err_q
        && $stable(chan_relay) && bus_relay == ($past(bus_relay)
        & $past({{4{intlk_ok[1]}}, {4{intlk_ok[0]}}})))
        else $error("refused request changed relays or gave no error");
    pair_close_a: assert property (@(posedge clk_sys) disable iff (reset)
        (take && ok && op == OP_CLOSE && pair && is_ch)
        |=> ##1 resp_valid_q && !resp_err_q
        && reed[0][tgt_local_q] && reed[1][tgt_local_q])
        else $error("four-wire pair not closed together");
    break_make_a: assert property (@(posedge clk_sys) disable iff (reset)
        scan_start_s |=> scan_break_s ##[1:300] resp_valid_q)
        else $error("scan step broke late or never finished");
    ident_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
        module_type_query |=> ident_valid_q && ident_code_q
        == (one_wire_q ? ID_ONE_WIRE : ID_TWO_WIRE))
        else $error("identity does not match active mode");
    mode_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        armed_q |=> $stable(one_wire_q))
        else $error("wire mode changed without power cycle");

endmodule

// [bench/ctrl_model.sv]
`timescale 1ns/1ns
module ctrl_model
    import reed_mux_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Command from the bench
    input  wire logic       go,
    input  wire logic [1:0] go_op,
    input  wire logic [6:0] go_chan,
    input  wire logic       go_fw,
    // Request to the block
    output logic            req_valid,
    output logic [1:0]      req_op,
    output logic [6:0]      req_chan,
    output logic            req_four_wire,
    input  wire logic       req_ready_q
);
    // Strobe held until the edge that sees ready high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            req_valid <= 1'b0;
        end else if (req_valid && req_ready_q) begin
            req_valid <= 1'b0;
        end else if (go) begin
            req_valid <= 1'b1;
        end
    end
    // Idle qualifiers churn, so a stale value is never mistaken for a live one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            req_op        <= 2'h0;
            req_chan      <= 7'h00;
            req_four_wire <= 1'b0;
        end else if (go && !req_valid) begin
            req_op        <= go_op;
            req_chan      <= go_chan;
            req_four_wire <= go_fw;
        end else if (!req_valid || req_ready_q) begin
            req_op        <= ~req_op;
            req_chan      <= ~req_chan;
            req_four_wire <= ~req_four_wire;
        end
    end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ns
module tb
    import reed_mux_pkg::*;
;
    typedef struct {
        logic        err;
        logic [79:0] ch;
        logic [7:0]  bus;
    } note_s;
    logic        clk_sys, reset, one_wire_sel, go, go_fw, query;
    logic [1:0]  intlk, go_op, req_op;
    logic [6:0]  go_chan, req_chan;
    logic        req_valid, req_fw, ready, rv, rerr, busy, idv, onew_q;
    logic [15:0] idc;
    logic [79:0] chan_relay, on_m;
    logic [7:0]  bus_relay, bus_m;
    logic        one_w;
    logic [31:0] lfsr_q;
    int          fails, cmp_count, cyc;
    note_s       notes[$];

    ctrl_model partner (.clk_sys(clk_sys), .reset(reset), .go(go),
        .go_op(go_op), .go_chan(go_chan), .go_fw(go_fw),
        .req_valid(req_valid), .req_op(req_op), .req_chan(req_chan),
        .req_four_wire(req_fw), .req_ready_q(ready));
    reed_mux_relay_controller dut (.clk_sys(clk_sys), .reset(reset),
        .one_wire_sel(one_wire_sel), .intlk_pin(intlk),
        .req_valid(req_valid), .req_op(req_op), .req_chan(req_chan),
        .req_four_wire(req_fw), .req_ready_q(ready), .resp_valid_q(rv),
        .resp_err_q(rerr), .scan_busy_q(busy), .module_type_query(query),
        .ident_valid_q(idv), .ident_code_q(idc), .one_wire_q(onew_q),
        .chan_relay(chan_relay), .bus_relay(bus_relay));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reed image of the closed request codes
    function automatic logic [79:0] image(input logic [79:0] on);
        logic [79:0] r;
        r = '0;
        for (int c = 0; c < 80; c++) begin
            if (on[c] && one_w) r[c] = 1'b1;
            else if (on[c] && c < 40) begin
                r[c + (c / 20) * 20] = 1'b1;
                r[c + (c / 20) * 20 + 20] = 1'b1;
            end
        end
        return r;
    endfunction

    // Bank load in half-channel units
    function automatic int load(input logic [79:0] on, input logic [7:0] bs,
                                input int b);
        int s, h;
        h = one_w ? 40 : 20;
        s = 0;
        for (int c = 0; c < 2 * h; c++) if (on[c] && c / h == b) s += 2;
        for (int k = 0; k < 4; k++) if (bs[b * 4 + k]) s += 1;
        return s;
    endfunction

    task automatic check(input string what, input logic [79:0] seen,
                         input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Predict the answer, note it, then hand the request to the partner
    task automatic issue(input logic [1:0] op, input logic [6:0] c,
                         input logic fw);
        note_s       n;
        logic [79:0] on;
        logic [7:0]  bs;
        logic        bad, isbus;
        int          k, h, t, nb, e;
        k = int'(c);
        h = one_w ? 40 : 20;
        on = (op == OP_SCAN || op == OP_OPEN_ALL) ? '0 : on_m;
        bs = bus_m;
        isbus = k >= 80 && k < 88;
        bad = (k >= 2 * h && !isbus) || (isbus && op == OP_SCAN)
            || (fw && (one_w || k >= 20))
            || (isbus && op == OP_CLOSE && !intlk[(k - 80) / 4]);
        if (!bad && op != OP_OPEN_ALL) begin
            if (isbus) bs[k - 80] = (op != OP_OPEN);
            else on[k] = (op != OP_OPEN);
            if (fw) on[k + 20] = (op != OP_OPEN);
        end
        if (load(on, bs, 0) > h || load(on, bs, 1) > h) bad = 1'b1;
        n.err = bad;
        if (!bad) begin
            on_m = on;
            bus_m = bs;
        end
        n.ch = image(on_m);
        n.bus = bus_m;
        notes.push_back(n);
        @(posedge clk_sys);
        go <= 1'b1;
        go_op <= op;
        go_chan <= c;
        go_fw <= fw;
        @(posedge clk_sys);
        go <= 1'b0;
        t = 0;
        nb = 0;
        do begin
            @(posedge clk_sys);
            t++;
            if (busy === 1'b1) nb++;
            if (busy === 1'b1) check("break", chan_relay, '0);
        end while (rv !== 1'b1 && t < 400);
        if (rv !== 1'b1) check("response", 80'h0, 80'h1);
        // Only an accepted scan opens a gap, and it lasts the full break
        e = (op == OP_SCAN && !bad) ? int'(BREAK_CYC) : 0;
        check("break cycles", 80'(nb), 80'(e));
    endtask

    task automatic restart(input logic ow);
        reset <= 1'b1;
        one_wire_sel <= ow;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        on_m = '0;
        bus_m = '0;
        one_w = ow;
        repeat (3) @(posedge clk_sys);
        one_wire_sel <= ~ow;
        check("relays", chan_relay, '0);
        check("bus", 80'(bus_relay), '0);
        query <= 1'b1;
        @(posedge clk_sys);
        query <= 1'b0;
        // Identity pulse stands one cycle, so look at the very next edge
        @(posedge clk_sys);
        check("ident valid", 80'(idv), 80'h1);
        check("ident", 80'(idc), 80'(ow ? ID_ONE_WIRE : ID_TWO_WIRE));
        check("mode", 80'(onew_q), 80'(ow));
    endtask

    // Take the oldest note whenever an answer shows
    always @(posedge clk_sys) begin
        if (rv === 1'b1) begin
            if (notes.size() == 0) check("spare answer", 80'h1, 80'h0);
            else begin
                check("error", 80'(rerr), 80'(notes[0].err));
                check("chan", chan_relay, notes[0].ch);
                check("bus", 80'(bus_relay), 80'(notes[0].bus));
                void'(notes.pop_front());
            end
        end
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        reset = 1'b1;
        one_wire_sel = 1'b0;
        go = 1'b0;
        go_op = 2'h0;
        go_chan = 7'h00;
        go_fw = 1'b0;
        query = 1'b0;
        intlk = 2'h3;
        lfsr_q = 32'h442CDE85;
        restart(1'b0);
        for (int k = 80; k < 88; k++) issue(OP_CLOSE, 7'(k), 1'b0);
        for (int k = 80; k < 88; k++) issue(OP_OPEN, 7'(k), 1'b0);
        issue(OP_CLOSE, 7'h50, 1'b0);
        // Tenth channel beside a bus relay overflows bank one
        for (int k = 0; k < 10; k++) issue(OP_CLOSE, 7'(k), 1'b0);
        for (int k = 20; k < 30; k++) issue(OP_CLOSE, 7'(k), 1'b0);
        issue(OP_CLOSE, 7'h54, 1'b0);
        @(posedge clk_sys);
        intlk <= 2'h2;
        repeat (8) @(posedge clk_sys);
        bus_m[3:0] = 4'h0;
        check("bus drop", 80'(bus_relay), 80'(bus_m));
        issue(OP_CLOSE, 7'h51, 1'b0);
        intlk <= 2'h3;
        repeat (8) @(posedge clk_sys);
        issue(OP_OPEN_ALL, 7'h00, 1'b0);
        issue(OP_CLOSE, 7'h03, 1'b1);
        issue(OP_CLOSE, 7'h04, 1'b0);
        issue(OP_CLOSE, 7'h19, 1'b1);
        issue(OP_SCAN, 7'h05, 1'b1);
        issue(OP_SCAN, 7'h1E, 1'b0);
        issue(OP_SCAN, 7'h52, 1'b0);
        issue(OP_OPEN, 7'h05, 1'b1);
        issue(OP_OPEN_ALL, 7'h00, 1'b0);
        repeat (60) begin
            lfsr_q = lfsr(lfsr_q);
            issue(on_m[lfsr_q[15:0] % 40] ? OP_OPEN : OP_CLOSE,
                  7'(lfsr_q[15:0] % 40), 1'b0);
        end
        restart(1'b1);
        for (int k = 0; k < 21; k++) issue(OP_CLOSE, 7'(k), 1'b0);
        issue(OP_CLOSE, 7'h50, 1'b0);
        issue(OP_CLOSE, 7'h30, 1'b1);
        for (int k = 40; k < 61; k++) issue(OP_CLOSE, 7'(k), 1'b0);
        issue(OP_SCAN, 7'h4F, 1'b0);
        end_of_test();
    end
endmodule
